// ==== verilog/watchdog_pkg.sv ====
// package of constants, types and functions for the parallel port watchdog
package watchdog_pkg;

	// host byte layout of the command lines and the echo line
	localparam logic [1:0] HOST_COMMAND_LINES_OFS = 2'h0;
	localparam logic [1:0] HOST_ECHO_LINES_OFS    = 2'h1;
	localparam int         CMD_DATA_BIT           = 2;
	localparam int         STROBE_N_BIT           = 1;
	localparam int         SELECT_N_BIT           = 0;
	localparam int         ECHO_N_BIT             = 7;

	// clock and timebase
	localparam int unsigned CLK_PERIOD_NS  = 5;
	localparam int unsigned MS_NS          = 1000000;
	localparam int unsigned MS_TICK_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// timeout intervals in milliseconds
	localparam logic [15:0] TIMEOUT_0_MS = 16'h0064; // 100 msec
	localparam logic [15:0] TIMEOUT_1_MS = 16'h03e8; // 1 sec
	localparam logic [15:0] TIMEOUT_2_MS = 16'h1388; // 5 sec
	localparam logic [15:0] TIMEOUT_3_MS = 16'h2710; // 10 sec
	localparam logic [15:0] TIMEOUT_4_MS = 16'h4e20; // 20 sec
	localparam logic [15:0] TIMEOUT_5_MS = 16'h9c40; // 40 sec
	localparam logic [15:0] TIMEOUT_6_MS = 16'hea60; // 60 sec

	// length of the cold reset pulse, in milliseconds
	localparam logic [15:0] RESET_PULSE_MS = 16'h00c8;

	// command encoding
	localparam logic [4:0] CMD_PREFIX      = 5'h19;
	localparam logic [2:0] CMD_RESTART_IDX = 3'h7;
	localparam logic [2:0] DEFAULT_SEL     = 3'h6;
	localparam logic [3:0] CMD_BITS        = 4'h8;
	localparam logic [3:0] CMD_OVERRUN     = 4'h9;

	typedef enum logic [2:0] {
		ST_PASSIVE = 3'b001,
		ST_ARMED   = 3'b010,
		ST_FIRING  = 3'b100
	} wd_state_t;

	function automatic logic cmd_valid(input logic [7:0] code);
		cmd_valid = (code[7:3] == CMD_PREFIX);
	endfunction

	function automatic logic [15:0] timeout_ms(input logic [2:0] sel);
		case (sel)
			3'h0:    timeout_ms = TIMEOUT_0_MS;
			3'h1:    timeout_ms = TIMEOUT_1_MS;
			3'h2:    timeout_ms = TIMEOUT_2_MS;
			3'h3:    timeout_ms = TIMEOUT_3_MS;
			3'h4:    timeout_ms = TIMEOUT_4_MS;
			3'h5:    timeout_ms = TIMEOUT_5_MS;
			default: timeout_ms = TIMEOUT_6_MS;
		endcase
	endfunction

endpackage

// ==== verilog/sync2.sv ====
// two flip-flop synchroniser for levels
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk) begin
		meta <= d;
	end

	always_ff @(posedge clk) begin
		q <= meta;
	end
endmodule // sync2

// ==== verilog/ms_prescaler.sv ====
// millisecond tick generator, restartable
`timescale 1ns/1ps
module ms_prescaler #(
	parameter int unsigned CYCLES = 1
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic clear,
	output logic      tick
);
	logic [31:0] count;

	always_ff @(posedge clk) begin
		if (!resetn || clear) begin
			count <= 32'h0;
			tick  <= 1'b0;
		end else if (count == CYCLES - 1) begin
			count <= 32'h0;
			tick  <= 1'b1;
		end else begin
			count <= count + 32'h1;
			tick  <= 1'b0;
		end
	end
endmodule // ms_prescaler

// ==== verilog/parallel_port_watchdog_timer.sv ====
// watchdog top: serial command receiver on the link clock, timeout logic on clk
//
// Behaviour
// RL1: after reset or a fired cold reset, stay passive until a valid command.
// RL2: seven timeouts: 100 ms, 1, 5, 10, 20, 40 and 60 seconds.
// RL3: codes c8h..ceh select those timeouts in ascending order.
// RL4: code cfh restarts the timeout counter.
// RL5: host sends the restart command more often than the timeout.
// RL6: timeout elapsed without restart drives the cold reset output.
// RL7: commands are eight bits, most significant bit first.
// RL8: host holds select and strobe high between commands.
// RL9: host starts each command by pulling select low.
// RL10: select falling makes the device drive echo high.
// RL11: per bit host sets data, lowers strobe, raises strobe, checks echo.
// RL12: device echoes each received bit; host checks and flags mismatches.
// RL13: host sends eight bits then raises select to end the transfer.
// RL14: host byte: bit 2 data, bit 1 strobe low, bit 0 select low.
// RL15: status byte bit 7 carries the active low echo line.
// RL16: act after eight bits and select high; new timeout restarts counter.
// RL17: ignore codes outside c8h..cfh; drop partial commands on early select.
`timescale 1ns/1ps
module parallel_port_watchdog_timer
	import watchdog_pkg::*;
#(
	parameter int unsigned MS_CYCLES = MS_TICK_CYCLES
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic link_clk,
	input  wire logic select_n,
	input  wire logic strobe_n,
	input  wire logic cmd_data,
	output logic      echo_n,
	output logic      cold_reset
);

	// link domain
	logic       link_resetn;
	logic [2:0] pins_s;
	logic       select_s;
	logic       strobe_s;
	logic       data_s;
	logic       select_prev;
	logic       strobe_prev;
	logic       select_fall;
	logic       select_rise;
	logic       strobe_rise;
	logic [3:0] bit_cnt;
	logic [7:0] shift_reg;
	logic [7:0] cmd_word;
	logic       cmd_toggle;

	sync2 #(
		.WIDTH (1)
	) u_link_reset_sync (
		.clk (link_clk),
		.d   (resetn),
		.q   (link_resetn)
	);

	sync2 #(
		.WIDTH (3)
	) u_pin_sync (
		.clk (link_clk),
		.d   ({cmd_data, strobe_n, select_n}),
		.q   (pins_s)
	);

	assign data_s   = pins_s[CMD_DATA_BIT]; // [RL14]
	assign strobe_s = pins_s[STROBE_N_BIT]; // [RL14]
	assign select_s = pins_s[SELECT_N_BIT]; // [RL14]

	always_ff @(posedge link_clk) begin
		if (!link_resetn) begin
			select_prev <= 1'b1;
			strobe_prev <= 1'b1;
		end else begin
			select_prev <= select_s;
			strobe_prev <= strobe_s;
		end
	end

	assign select_fall = select_prev && !select_s;
	assign select_rise = !select_prev && select_s;
	// strobe return to high closes one bit cycle
	assign strobe_rise = !strobe_prev && strobe_s && !select_s;

	// bit counter, saturates at overrun so a ninth bit spoils the command
	always_ff @(posedge link_clk) begin
		if (!link_resetn) begin
			bit_cnt <= 4'h0;
		end else if (select_fall) begin
			bit_cnt <= 4'h0;
		end else if (strobe_rise && bit_cnt != CMD_OVERRUN) begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// the line carries the inverted bit; first bit ends up in the msb
	always_ff @(posedge link_clk) begin
		if (!link_resetn) begin
			shift_reg <= 8'h00;
		end else if (select_fall) begin
			shift_reg <= 8'h00;
		end else if (strobe_rise) begin
			shift_reg <= {shift_reg[6:0], !data_s}; // [RL7]
		end
	end

	// echo line: high on select, then the received bit
	always_ff @(posedge link_clk) begin
		if (!link_resetn) begin
			echo_n <= 1'b1;
		end else if (select_fall) begin
			echo_n <= 1'b1; // [RL10]
		end else if (strobe_rise) begin
			echo_n <= !data_s; // [RL12] [RL15]
		end
	end

	// hand a complete command over when select returns high
	always_ff @(posedge link_clk) begin
		if (!link_resetn) begin
			cmd_word   <= 8'h00;
			cmd_toggle <= 1'b0;
		end else if (select_rise && bit_cnt == CMD_BITS) begin
			cmd_word   <= shift_reg; // [RL16]
			cmd_toggle <= !cmd_toggle; // [RL16]
		end
	end

	// clk domain
	logic        toggle_s;
	logic        toggle_seen;
	logic        cmd_take;
	logic [7:0]  cmd_code;
	logic        code_ok;
	logic        code_restart;
	logic        cmd_act;
	logic        ms_tick;
	logic        tick_clear;
	logic [15:0] ms_count;
	logic [2:0]  sel_idx;
	logic        expire;
	logic        pulse_done;
	wd_state_t   state;
	wd_state_t   next_state;

	sync2 #(
		.WIDTH (1)
	) u_toggle_sync (
		.clk (clk),
		.d   (cmd_toggle),
		.q   (toggle_s)
	);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			toggle_seen <= 1'b0;
		end else begin
			toggle_seen <= toggle_s;
		end
	end

	// cmd_word has been still for two clk edges when the toggle lands
	assign cmd_take     = toggle_s ^ toggle_seen;
	assign cmd_code     = cmd_word;
	assign code_ok      = cmd_valid(cmd_code);
	assign code_restart = (cmd_code[2:0] == CMD_RESTART_IDX);
	// commands are ignored while the reset pulse is out
	assign cmd_act      = cmd_take && code_ok && state != ST_FIRING; // [RL17]

	assign expire     = ms_tick && ms_count == timeout_ms(sel_idx) - 16'h1;
	assign pulse_done = ms_tick && ms_count == RESET_PULSE_MS - 16'h1;
	assign tick_clear = cmd_act || (state == ST_ARMED && expire);

	ms_prescaler #(
		.CYCLES (MS_CYCLES)
	) u_ms_prescaler (
		.clk    (clk),
		.resetn (resetn),
		.clear  (tick_clear),
		.tick   (ms_tick)
	);

	always_comb begin
		next_state = state;
		case (state)
			ST_PASSIVE: begin
				if (cmd_act) begin
					next_state = ST_ARMED; // [RL1]
				end
			end
			ST_ARMED: begin
				if (!cmd_act && expire) begin
					next_state = ST_FIRING; // [RL6]
				end
			end
			ST_FIRING: begin
				if (pulse_done) begin
					next_state = ST_PASSIVE; // [RL1]
				end
			end
			default: begin
				next_state = ST_PASSIVE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= ST_PASSIVE;
		end else begin
			state <= next_state;
		end
	end

	// timeout selection
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sel_idx <= DEFAULT_SEL;
		end else if (cmd_act && !code_restart) begin
			sel_idx <= cmd_code[2:0]; // [RL2] [RL3]
		end
	end

	// millisecond counter, reused for the reset pulse length
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ms_count <= 16'h0;
		end else if (cmd_act) begin
			ms_count <= 16'h0; // [RL4] [RL16]
		end else if (state == ST_ARMED && expire) begin
			ms_count <= 16'h0;
		end else if (state == ST_FIRING && pulse_done) begin
			ms_count <= 16'h0;
		end else if (state != ST_PASSIVE && ms_tick) begin
			ms_count <= ms_count + 16'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cold_reset <= 1'b0;
		end else begin
			cold_reset <= (next_state == ST_FIRING); // [RL6]
		end
	end

	// checks
	sequence expire_seq;
		state == ST_ARMED && expire && !cmd_act;
	endsequence

	sequence pulse_seq;
		cold_reset ##1 cold_reset;
	endsequence

	sequence restart_seq;
		cmd_act && code_restart;
	endsequence

	passive_quiet_a: assert property (@(posedge clk) disable iff (!resetn) // [RL1]
		state == ST_PASSIVE |-> !cold_reset)
		else $error("cold reset while passive");

	timeout_select_a: assert property (@(posedge clk) disable iff (!resetn) // [RL3]
		cmd_act && !code_restart |=> sel_idx == $past(cmd_code[2:0]) && ms_count == 16'h0)
		else $error("timeout select not taken");

	restart_clear_a: assert property (@(posedge clk) disable iff (!resetn) // [RL4]
		restart_seq |=> ms_count == 16'h0 && state == ST_ARMED && $stable(sel_idx))
		else $error("restart did not clear counter");

	expire_fire_a: assert property (@(posedge clk) disable iff (!resetn) // [RL6]
		expire_seq |=> pulse_seq)
		else $error("expiry did not raise cold reset");

	limit_exact_a: assert property (@(posedge clk) disable iff (!resetn) // [RL2]
		state == ST_ARMED && ms_tick && !cmd_act
			&& ms_count != timeout_ms(sel_idx) - 16'h1 |=> !cold_reset)
		else $error("cold reset before timeout");

	bad_code_a: assert property (@(posedge clk) disable iff (!resetn) // [RL17]
		cmd_take && !code_ok && !ms_tick |=> $stable(state) && $stable(sel_idx))
		else $error("invalid code acted on");

	select_echo_a: assert property (@(posedge link_clk) disable iff (!link_resetn) // [RL10]
		select_fall |=> echo_n && bit_cnt == 4'h0)
		else $error("echo not high after select");

	bit_echo_a: assert property (@(posedge link_clk) disable iff (!link_resetn) // [RL12]
		strobe_rise |=> echo_n == !$past(data_s) && shift_reg[0] == echo_n)
		else $error("echo does not match bit");

	msb_first_a: assert property (@(posedge link_clk) disable iff (!link_resetn) // [RL7]
		strobe_rise |=> shift_reg[7:1] == $past(shift_reg[6:0]))
		else $error("bit order wrong");

	full_cmd_a: assert property (@(posedge link_clk) disable iff (!link_resetn) // [RL16]
		select_rise && bit_cnt == CMD_BITS |=> cmd_toggle != $past(cmd_toggle)
			&& cmd_word == $past(shift_reg))
		else $error("complete command not handed over");

	partial_drop_a: assert property (@(posedge link_clk) disable iff (!link_resetn) // [RL17]
		select_rise && bit_cnt != CMD_BITS |=> $stable(cmd_toggle))
		else $error("partial command handed over");

	passive_hold_a: assert property (@(posedge clk) disable iff (!resetn) // [RL1]
		state == ST_PASSIVE && !cmd_act |=> state == ST_PASSIVE)
		else $error("left passive without command");

	arm_any_a: assert property (@(posedge clk) disable iff (!resetn) // [RL16]
		state == ST_PASSIVE && cmd_act |=> state == ST_ARMED && ms_count == 16'h0)
		else $error("valid command did not arm");

	armed_stay_a: assert property (@(posedge clk) disable iff (!resetn) // [RL6]
		state == ST_ARMED && !expire |=> state == ST_ARMED && !cold_reset)
		else $error("left armed before expiry");

	pulse_hold_a: assert property (@(posedge clk) disable iff (!resetn) // [RL6]
		state == ST_FIRING && !pulse_done |=> state == ST_FIRING && cold_reset)
		else $error("cold reset pulse cut short");

	pulse_end_a: assert property (@(posedge clk) disable iff (!resetn) // [RL1]
		state == ST_FIRING && pulse_done |=> state == ST_PASSIVE && !cold_reset)
		else $error("cold reset pulse did not end");

	tick_single_a: assert property (@(posedge clk) disable iff (!resetn) // [RL2]
		ms_tick |=> !ms_tick)
		else $error("millisecond tick too long");

	count_bound_a: assert property (@(posedge clk) disable iff (!resetn) // [RL2]
		state == ST_ARMED |-> ms_count < timeout_ms(sel_idx))
		else $error("counter past timeout");

	echo_stand_a: assert property (@(posedge link_clk) disable iff (!link_resetn) // [RL12]
		!strobe_rise && !select_fall |=> $stable(echo_n))
		else $error("echo changed without strobe");

	count_stand_a: assert property (@(posedge link_clk) disable iff (!link_resetn) // [RL7]
		!strobe_rise && !select_fall |=> $stable(bit_cnt))
		else $error("bit count changed without strobe");

endmodule // parallel_port_watchdog_timer

// ==== tb/host_port_model.sv ====
// host parallel port model: shifts commands out and collects echoes
`timescale 1ns/1ps
module host_port_model
	import watchdog_pkg::*;
(
	input  wire logic link_clk,
	input  wire logic echo_n,
	output logic      select_n,
	output logic      strobe_n,
	output logic      cmd_data
);
	logic [7:0] host_command_lines;
	logic [7:0] host_echo_lines;

	assign select_n = host_command_lines[SELECT_N_BIT];
	assign strobe_n = host_command_lines[STROBE_N_BIT];
	assign cmd_data = host_command_lines[CMD_DATA_BIT];
	assign host_echo_lines = {echo_n, 7'h00};

	initial begin
		host_command_lines = 8'h07;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge link_clk);
		#1;
	endtask

	// data line carries the inverted bit; extra stretches strobe low
	task automatic send(input logic [7:0] code, input int nbits, input int extra,
		output logic [8:0] echo);
		echo = 9'h000;
		hold(1);
		host_command_lines[SELECT_N_BIT] = 1'b0;
		hold(5);
		echo[8] = host_echo_lines[ECHO_N_BIT];
		for (int i = 0; i < nbits; i++) begin
			host_command_lines[CMD_DATA_BIT] = ~code[7 - i];
			hold(3);
			host_command_lines[STROBE_N_BIT] = 1'b0;
			hold(3 + extra);
			host_command_lines[STROBE_N_BIT] = 1'b1;
			hold(4);
			echo[7 - i] = host_echo_lines[ECHO_N_BIT];
		end
		host_command_lines[SELECT_N_BIT] = 1'b1;
		hold(1);
		// released data line must not keep its last level
		host_command_lines[CMD_DATA_BIT] = ~host_command_lines[CMD_DATA_BIT];
		// select stays high four link periods before the next command
		hold(2);
	endtask
endmodule // host_port_model

// ==== tb/tb_top.sv ====
// self-checking bench for the parallel port watchdog
`timescale 1ns/1ps
module tb_top
	import watchdog_pkg::*;
;
	localparam int MSC = 10;
	logic       clk      = 1'b0;
	logic       link_clk = 1'b0;
	logic       resetn   = 1'b0;
	logic       select_n;
	logic       strobe_n;
	logic       cmd_data;
	logic       echo_n;
	logic       cold_reset;
	logic [8:0] echo;
	logic [7:0] code;
	int         err_total   = 0;
	int         comparisons = 0;
	int         seed        = 32'ha29d;
	logic [15:0] ms_tab [3] = '{TIMEOUT_0_MS, TIMEOUT_1_MS, TIMEOUT_2_MS};

	always #2.5 clk = ~clk;

	// link clock with its own phase
	initial begin
		#17.3;
		forever #80 link_clk = ~link_clk;
	end

	parallel_port_watchdog_timer #(.MS_CYCLES(MSC)) DUT (
		.clk(clk), .resetn(resetn), .link_clk(link_clk), .select_n(select_n),
		.strobe_n(strobe_n), .cmd_data(cmd_data), .echo_n(echo_n),
		.cold_reset(cold_reset));

	host_port_model host (
		.link_clk(link_clk), .echo_n(echo_n), .select_n(select_n),
		.strobe_n(strobe_n), .cmd_data(cmd_data));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic send_full(input logic [7:0] c);
		host.send(c, 8, $unsigned($random(seed)) % 3, echo);
		check(32'(echo), {23'h0, 1'b1, c}, "echo pattern");
	endtask

	task automatic quiet(input int n);
		logic hit;
		hit = 1'b0;
		repeat (n) begin
			@(negedge clk);
			if (cold_reset !== 1'b0) hit = 1'b1;
		end
		check(32'(hit), 32'h0, "reset while passive");
	endtask

	// time from the command handover, three link periods after select rise, to cold reset, then pulse width
	task automatic expire(input int ms);
		int n;
		n = 0;
		while (cold_reset !== 1'b1 && n <= ms * MSC + 200) begin
			@(negedge clk);
			n++;
		end
		if (cold_reset !== 1'b1) begin
			check(32'h0, 32'h1, "no cold reset");
			stop_test();
		end
		check(32'(n >= ms * MSC && n <= ms * MSC + 20), 32'h1, "timeout length");
		n = 0;
		while (cold_reset === 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		check(32'(n >= RESET_PULSE_MS * MSC - 2 && n <= RESET_PULSE_MS * MSC + 2),
			32'h1, "pulse width");
		if (n >= 3000) stop_test();
	endtask

	initial begin
		repeat (130) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (6) @(posedge link_clk);
		#1;
		check(32'(echo_n), 32'h1, "echo idle");
		check(32'(cold_reset), 32'h0, "reset idle");
		for (int i = 0; i < 2; i++) begin
			code = 8'($random(seed));
			if (code[7:3] == 5'h19) code[3] = ~code[3];
			send_full(code);
		end
		host.send(8'hc8, 5, 0, echo);
		quiet(1500);
		$display("test passive done");
		for (int i = 0; i < 3; i++) begin
			send_full(8'(8'hc8 + i));
			if (i == 1) send_full(8'hcf);
			expire(int'(ms_tab[i]));
			if (i == 0) quiet(1500);
			$display("test timeout %0d done", i);
		end
		for (int i = 3; i < 7; i++) begin
			send_full(8'(8'hc8 + i));
		end
		quiet(1200);
		$display("test long selections done");
		stop_test();
	end
endmodule // tb_top
